// ### rtl/dppr_regs.sv
// register bank for downstream port power, charging and over-current control
`timescale 1ns/1ps
module dppr_regs (
   input wire logic sys_clk, // 200 MHz system clock
   input wire logic nrst, // asynchronous reset, active low
   input wire logic clk_en, // freezes all state when low
   input wire logic reg_wr, // write strobe from the serial port
   input wire logic reg_rd, // read strobe from the serial port
   input wire logic [7:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // write data
   input wire logic [3:1] host_pwr_req, // host power request per port
   input wire logic overcurrent_pin_select, // interlock pin select bit
   input wire logic overcurrent_sense_pin_n, // sense pin, active low
   output logic [7:0] reg_rdata, // registered read data
   output logic [3:1] bc_enable, // charging support per port
   output logic [3:1] port_pwr_en, // actual port power switch
   output logic [3:1] hub_oc_status // over-current reported to host
);
   import dppr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // register state
   logic [7:0] bc_mask_ff; // charging enable mask
   logic [7:0] nxt_bc_mask;
   logic [7:0] oc_ctrl_ff; // over-current control
   logic [7:0] nxt_oc_ctrl;
   logic [7:0] rdata_ff; // read data
   logic [7:0] nxt_rdata;
   logic [3:1] battery_charge_enable_mask_ff; // charging outputs
   logic [3:1] nxt_battery_charge_enable_mask;
   logic [3:1] pwr_en_ff; // port power outputs
   logic [3:1] nxt_pwr_en;
   logic [3:1] oc_stat_ff; // over-current outputs
   logic [3:1] nxt_oc_stat;
   logic [3:1] eff_oc; // effective over-current per port
   logic [3:1] pwr_status; // live power status bits

   // implemented port bits only, so reserved bits stay zero
   function automatic logic [7:0] port_only(input logic [7:0] d);
      port_only = d & DPPR_PORT_BITS;
   endfunction : port_only

   ////////////////////////////////////////////////////////////////////////////
   // per-port effective over-current and status
   genvar gi;
   generate
      for (gi = DPPR_FIRST_PORT; gi <= DPPR_PORT3_BIT; gi++) begin : g_port
         if (gi == DPPR_PORT3_BIT) begin : g_p3
            // pin takes over port 3 when selected; pin low means fault
            assign eff_oc[gi] = overcurrent_pin_select ? ~overcurrent_sense_pin_n
               : oc_ctrl_ff[gi];
         end else begin : g_p12
            assign eff_oc[gi] = oc_ctrl_ff[gi];
         end
         // status: host request and no over-current
         assign pwr_status[gi] = host_pwr_req[gi] & ~eff_oc[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // next-state computation
   always_comb begin
      nxt_bc_mask = bc_mask_ff;
      nxt_oc_ctrl = oc_ctrl_ff;
      nxt_rdata = rdata_ff;
      // writes; status register has no write path
      if (reg_wr) begin
         if (reg_addr == DPPR_ADDR_BATTERY_CHARGE_ENABLE_MASK_MASK) begin
            nxt_bc_mask = port_only(reg_wdata);
         end else if (reg_addr == DPPR_ADDR_OC_CTRL) begin
            // bits 7..4 dropped whatever software writes
            nxt_oc_ctrl = port_only(reg_wdata);
            if (overcurrent_pin_select) begin
               nxt_oc_ctrl[DPPR_PORT3_BIT] = 1'b0;
            end
         end
      end
      // reads, unmapped addresses answer zero
      if (reg_rd) begin
         case (reg_addr)
            DPPR_ADDR_BATTERY_CHARGE_ENABLE_MASK_MASK: nxt_rdata = bc_mask_ff;
            DPPR_ADDR_PWR_STATUS: nxt_rdata = {4'h0, pwr_status, 1'b0};
            DPPR_ADDR_OC_CTRL: nxt_rdata = oc_ctrl_ff;
            default: nxt_rdata = 8'h00;
         endcase
      end
      // charging follows mask bits of ports 3..1
      nxt_battery_charge_enable_mask = bc_mask_ff[3:1];
      // power needs a host request or a charging mask bit, and no fault
      nxt_pwr_en = (host_pwr_req | bc_mask_ff[3:1]) & ~eff_oc;
      nxt_oc_stat = eff_oc;
   end

   ////////////////////////////////////////////////////////////////////////////
   // state registers
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         bc_mask_ff <= DPPR_RST_BATTERY_CHARGE_ENABLE_MASK_MASK;
         oc_ctrl_ff <= DPPR_RST_OC_CTRL;
         rdata_ff <= 8'h00;
         battery_charge_enable_mask_ff <= 3'h0;
         pwr_en_ff <= 3'h0;
         oc_stat_ff <= 3'h0;
      end else if (clk_en) begin
         bc_mask_ff <= nxt_bc_mask;
         oc_ctrl_ff <= nxt_oc_ctrl;
         rdata_ff <= nxt_rdata;
         battery_charge_enable_mask_ff <= nxt_battery_charge_enable_mask;
         pwr_en_ff <= nxt_pwr_en;
         oc_stat_ff <= nxt_oc_stat;
      end
   end

   assign reg_rdata = rdata_ff;
   assign bc_enable = battery_charge_enable_mask_ff;
   assign port_pwr_en = pwr_en_ff;
   assign hub_oc_status = oc_stat_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   AST_BC_FOLLOWS: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en |=> bc_enable == $past(bc_mask_ff[3:1])) else $error("charge enable wrong");
   AST_MASK_RSVD: assert property (@(posedge sys_clk) disable iff (!nrst)
      (bc_mask_ff & ~DPPR_PORT_BITS) == 8'h00) else $error("mask reserved bit set");
   AST_OC_RSVD: assert property (@(posedge sys_clk) disable iff (!nrst)
      oc_ctrl_ff[7:4] == 4'h0 && !oc_ctrl_ff[0]) else $error("oc reserved bit set");
   AST_STATUS_RO: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && reg_wr && reg_addr == DPPR_ADDR_PWR_STATUS |=> $stable(bc_mask_ff)
      && $stable(oc_ctrl_ff)) else $error("status write changed state");
   AST_STATUS_READ: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && reg_rd && reg_addr == DPPR_ADDR_PWR_STATUS
      |=> reg_rdata[3:1] == $past(host_pwr_req & ~eff_oc)) else $error("status read wrong");
   AST_OC_CLEARS: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && reg_wr && reg_addr == DPPR_ADDR_OC_CTRL && reg_wdata[1]
      |=> !pwr_status[1] ##1 (!port_pwr_en[1] || !$past(clk_en))) else $error("oc did not clear");
   AST_PIN_P3: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && overcurrent_pin_select |=> hub_oc_status[3] == $past(!overcurrent_sense_pin_n))
      else $error("port 3 pin not used");
   AST_REG_P3: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && !overcurrent_pin_select |=> hub_oc_status[3] == $past(oc_ctrl_ff[3]))
      else $error("port 3 reg not used");
   AST_PWR_MIX: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && eff_oc[2] |=> !port_pwr_en[2]) else $error("power on during fault");
   AST_RD_RSVD: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_rdata[0] == 1'b0 && reg_rdata[7:4] == 4'h0) else $error("reserved bit read");
   // unmapped addresses answer zero; software may probe the map safely
   AST_UNMAPPED_RD: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && reg_rd && reg_addr != DPPR_ADDR_BATTERY_CHARGE_ENABLE_MASK_MASK
      && reg_addr != DPPR_ADDR_PWR_STATUS && reg_addr != DPPR_ADDR_OC_CTRL
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   // reset forces every output low, checked without disable so reset is seen
   AST_RST_OUTS: assert property (@(posedge sys_clk)
      !nrst |-> reg_rdata == 8'h00 && bc_enable == 3'h0 && port_pwr_en == 3'h0
      && hub_oc_status == 3'h0) else $error("outputs not clear in reset");
   // register contents after reset are the documented zeros
   AST_RST_REGS: assert property (@(posedge sys_clk)
      !nrst |-> bc_mask_ff == DPPR_RST_BATTERY_CHARGE_ENABLE_MASK_MASK && oc_ctrl_ff == DPPR_RST_OC_CTRL)
      else $error("registers not clear in reset");
   // a mask write keeps only the port bits, reserved ones dropped
   AST_MASK_WR: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && reg_wr && reg_addr == DPPR_ADDR_BATTERY_CHARGE_ENABLE_MASK_MASK
      |=> bc_mask_ff == ($past(reg_wdata) & DPPR_PORT_BITS)) else $error("mask write wrong");
   // ports 1 and 2 always report the software bit
   AST_OC_P12: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en |=> hub_oc_status[2:1] == $past(oc_ctrl_ff[2:1])) else $error("oc 1,2 report");
   // no port is powered while its over-current is active
   AST_PWR_OFF_FAULT: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en |=> (port_pwr_en & $past(eff_oc)) == 3'h0) else $error("power on during fault");
   // status shows zero without a host request or with a fault
   AST_STATUS_ZERO: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && reg_rd && reg_addr == DPPR_ADDR_PWR_STATUS
      |=> (reg_rdata[3:1] & $past(~host_pwr_req | eff_oc)) == 3'h0) else $error("status not 0");
   // with the pin selected a write cannot set bit 3
   AST_P3_WR_BLOCK: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && reg_wr && reg_addr == DPPR_ADDR_OC_CTRL && overcurrent_pin_select
      |=> !oc_ctrl_ff[DPPR_PORT3_BIT]) else $error("oc bit 3 written");
   // the pin is active low: a low level means a fault on port 3
   AST_PIN_LOW: assert property (@(posedge sys_clk) disable iff (!nrst)
      clk_en && overcurrent_pin_select && !overcurrent_sense_pin_n
      |=> hub_oc_status[3]) else $error("pin low not reported");
   // clock enable low freezes the registers and the read data
   AST_FREEZE: assert property (@(posedge sys_clk) disable iff (!nrst)
      !clk_en |=> $stable(bc_mask_ff) && $stable(oc_ctrl_ff) && $stable(reg_rdata))
      else $error("state moved while frozen");
endmodule : dppr_regs

// ### common/dppr_pkg.sv
// constants for the downstream port power register bank
package dppr_pkg;
   localparam logic [7:0] DPPR_ADDR_BATTERY_CHARGE_ENABLE_MASK_MASK = 8'hd0; // charging enable mask
   localparam logic [7:0] DPPR_ADDR_PWR_STATUS = 8'he5; // port power status
   localparam logic [7:0] DPPR_ADDR_OC_CTRL = 8'he6; // over-current control
   localparam logic [7:0] DPPR_RST_BATTERY_CHARGE_ENABLE_MASK_MASK = 8'h00; // mask reset value
   localparam logic [7:0] DPPR_RST_OC_CTRL = 8'h00; // over-current reset value
   localparam logic [7:0] DPPR_PORT_BITS = 8'h0e; // implemented bits 3..1
   localparam int DPPR_PORT3_BIT = 3; // bit of port 3
   localparam int DPPR_FIRST_PORT = 1; // lowest port bit
endpackage : dppr_pkg

// ### sim/dppr_soc_model.sv
// far-side model: the system-on-chip driving the register strobes
`timescale 1ns/1ps
module dppr_soc_model (
   input wire logic sys_clk, // shared system clock
   input wire logic [7:0] reg_rdata, // read data from the bank
   output logic reg_wr, // write strobe
   output logic reg_rd, // read strobe
   output logic [7:0] reg_addr, // register address
   output logic [7:0] reg_wdata // write data
);
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one-cycle write; idle lines show inverted values so stale data never helps
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d & 8'h0f;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask : wr
   // one-cycle read, data taken once the registered answer settles
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      @(negedge sys_clk);
      d = reg_rdata;
   endtask : rd
endmodule : dppr_soc_model

// ### sim/tb.sv
// self-checking bench for the port power register bank
`timescale 1ns/1ps
module tb;
   import dppr_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic clk_en = 1'b1;
   logic [3:1] host_pwr_req = 3'h0;
   logic overcurrent_pin_select = 1'b0;
   logic overcurrent_sense_pin_n = 1'b1;
   logic reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d, a, w;
   logic [3:1] bc_enable, port_pwr_en, hub_oc_status;
   logic [7:0] m_exp = 8'h00; // expected mask
   logic [7:0] o_exp = 8'h00; // expected over-current register
   logic [7:0] adr_tab [3] = '{DPPR_ADDR_BATTERY_CHARGE_ENABLE_MASK_MASK, DPPR_ADDR_PWR_STATUS, DPPR_ADDR_OC_CTRL};
   int num_errors = 0;
   int check_count = 0;
   always #2.5 sys_clk = ~sys_clk;
   dppr_regs dppr_regs_inst (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .host_pwr_req(host_pwr_req),
      .overcurrent_pin_select(overcurrent_pin_select), .reg_rdata(reg_rdata),
      .overcurrent_sense_pin_n(overcurrent_sense_pin_n), .bc_enable(bc_enable),
      .port_pwr_en(port_pwr_en), .hub_oc_status(hub_oc_status));
   dppr_soc_model dppr_soc_model_inst (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   ////////////////////////////////////////////////////////////////////////////
   // effective over-current; the sense pin owns port 3 when selected
   function automatic logic [3:1] oc_eff();
      return {overcurrent_pin_select ? ~overcurrent_sense_pin_n : o_exp[3], o_exp[2:1]};
   endfunction : oc_eff
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
      dppr_soc_model_inst.rd(adr, d);
      chk(d, exp);
   endtask : rd_chk
   task automatic close_out();
      if (num_errors == 0 && check_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   ////////////////////////////////////////////////////////////////////////////
   // watchdog: the whole run needs well under a thousand cycles
   initial begin
      #20000;
      num_errors++;
      close_out();
   end
   // corners first, then random traffic with random pin levels
   initial begin
      void'($urandom(32'he111b8cc));
      repeat (10) @(posedge sys_clk);
      nrst <= 1'b1;
      rd_chk(DPPR_ADDR_BATTERY_CHARGE_ENABLE_MASK_MASK, DPPR_RST_BATTERY_CHARGE_ENABLE_MASK_MASK);
      rd_chk(DPPR_ADDR_OC_CTRL, DPPR_RST_OC_CTRL);
      rd_chk(8'h00, 8'h00);
      @(posedge sys_clk);
      clk_en <= 1'b0;
      dppr_soc_model_inst.wr(DPPR_ADDR_BATTERY_CHARGE_ENABLE_MASK_MASK, 8'h0e);
      clk_en <= 1'b1;
      rd_chk(DPPR_ADDR_BATTERY_CHARGE_ENABLE_MASK_MASK, 8'h00);
      for (int i = 0; i < 60; i++) begin
         @(posedge sys_clk);
         host_pwr_req <= 3'($urandom());
         overcurrent_pin_select <= 1'($urandom());
         overcurrent_sense_pin_n <= 1'($urandom());
         a = (i % 4 == 3) ? 8'($urandom()) : adr_tab[i % 4];
         w = 8'($urandom()) & 8'h0f;
         repeat (2) @(posedge sys_clk);
         dppr_soc_model_inst.wr(a, w);
         if (a === DPPR_ADDR_BATTERY_CHARGE_ENABLE_MASK_MASK) m_exp = w & DPPR_PORT_BITS;
         if (a === DPPR_ADDR_OC_CTRL) o_exp = w & (overcurrent_pin_select ? 8'h06 : 8'h0e);
         rd_chk(DPPR_ADDR_BATTERY_CHARGE_ENABLE_MASK_MASK, m_exp);
         rd_chk(DPPR_ADDR_OC_CTRL, o_exp);
         rd_chk(DPPR_ADDR_PWR_STATUS, {4'h0, host_pwr_req & ~oc_eff(), 1'b0});
         chk({5'h0, bc_enable}, {5'h0, m_exp[3:1]});
         chk({5'h0, port_pwr_en}, {5'h0, (host_pwr_req | m_exp[3:1]) & ~oc_eff()});
         chk({5'h0, hub_oc_status}, {5'h0, oc_eff()});
      end
      // mid-run reset: power, charge, over-current and read bits 7..3 drop, registers come back as zero
      @(posedge sys_clk);
      nrst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      chk({reg_rdata[7:3], port_pwr_en}, 8'h00);
      chk({5'h0, bc_enable | hub_oc_status}, 8'h00);
      nrst <= 1'b1;
      m_exp = 8'h00;
      o_exp = 8'h00;
      rd_chk(DPPR_ADDR_BATTERY_CHARGE_ENABLE_MASK_MASK, DPPR_RST_BATTERY_CHARGE_ENABLE_MASK_MASK);
      rd_chk(DPPR_ADDR_OC_CTRL, DPPR_RST_OC_CTRL);
      close_out();
   end
endmodule : tb
